// *** design/occsc_divider.sv ***
// Edge-counting output divider, ratio is ratio_m1 plus one; a ratio_m1 of zero holds div_out high.
// Assumes src_rise is a one-cycle pulse per source rising edge.
`timescale 1ns/1ns
`default_nettype none
module occsc_divider (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Source and setting
  input wire logic src_rise,
  input wire logic [7:0] ratio_m1,
  // Divided level
  output logic div_out
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic next_div_out;

  always_comb begin
    next_count = count;
    // Clamp keeps a lowered ratio from running the counter to 255
    if (src_rise) begin
      if (count >= ratio_m1) begin
        next_count = 8'h00;
      end else begin
        next_count = count + 8'h01;
      end
    end
    next_div_out = (next_count <= (ratio_m1 >> 1));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 8'h00;
      div_out <= 1'b0;
    end else begin
      count <= next_count;
      div_out <= next_div_out;
    end
  end
endmodule // occsc_divider
`default_nettype wire

// *** design/occsc_sync.sv ***
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level or a clock well below hclk / 2.
`timescale 1ns/1ns
`default_nettype none
module occsc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // First stage is read only by the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // occsc_sync
`default_nettype wire

// *** design/occsc_top.sv ***
// Channel six output control: registers, source mux, divider, driver decode.
// Assumes one AHB-Lite master and clock sources from outside the hclk domain.
`timescale 1ns/1ns
`default_nettype none
module occsc_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock sources, asynchronous to hclk
  input wire logic pll1_clk,
  input wire logic pll2_clk,
  input wire logic ref_pri_clk,
  input wire logic ref_sec_clk,
  // Output pins
  output logic out_p,
  output logic out_p_oe,
  output logic out_n,
  output logic out_n_oe,
  // Driver settings for the analog stage
  output logic [1:0] driver_format,
  output logic [1:0] tail_current_sel,
  output logic [1:0] hcsl_load_sel
);
  logic [7:0] channel_six_output_control;
  logic [7:0] channel_six_output_divider;
  logic [7:0] next_control;
  logic [7:0] next_divider;
  logic wr_pend;
  logic next_wr_pend;
  logic [9:0] addr_q;
  logic [9:0] next_addr_q;
  logic [31:0] next_hrdata;
  logic take;
  logic [1:0] source_select;
  logic [1:0] driver_mode_first;
  logic [1:0] driver_mode_second;
  logic [3:0] src_sync;
  logic src_level;
  logic src_prev;
  logic src_rise;
  logic div_level;
  logic chan_clk;
  logic next_out_p;
  logic next_out_p_oe;
  logic next_out_n;
  logic next_out_n_oe;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = occsc_pkg::HRESP_OKAY;
  assign take = hsel && hready && (htrans == occsc_pkg::HTRANS_NONSEQ);

  // Register file: address phase captured, write done in data phase
  always_comb begin
    next_control = channel_six_output_control;
    next_divider = channel_six_output_divider;
    if (wr_pend && addr_q == occsc_pkg::CTL_ADDR) begin
      next_control = hwdata[7:0];
    end
    if (wr_pend && addr_q == occsc_pkg::DIV_ADDR) begin
      next_divider = hwdata[7:0];
    end
    next_wr_pend = take && hwrite;
    next_addr_q = take ? haddr[occsc_pkg::ADDR_BITS-1:0] : addr_q;
    // Read data from next values so a read right after a write sees it
    next_hrdata = hrdata;
    if (take && !hwrite) begin
      if (haddr[31:occsc_pkg::ADDR_BITS] != '0) begin
        next_hrdata = 32'h00000000;
      end else if (haddr[9:0] == occsc_pkg::CTL_ADDR) begin
        next_hrdata = {24'h000000, next_control};
      end else if (haddr[9:0] == occsc_pkg::DIV_ADDR) begin
        next_hrdata = {24'h000000, next_divider};
      end else begin
        next_hrdata = 32'h00000000;
      end
    end
    if (take && haddr[31:occsc_pkg::ADDR_BITS] != '0) begin
      next_wr_pend = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_six_output_control <= occsc_pkg::CTL_RESET;
      channel_six_output_divider <= occsc_pkg::DIV_RESET;
      wr_pend <= 1'b0;
      addr_q <= '0;
      hrdata <= 32'h00000000;
    end else begin
      channel_six_output_control <= next_control;
      channel_six_output_divider <= next_divider;
      wr_pend <= next_wr_pend;
      addr_q <= next_addr_q;
      hrdata <= next_hrdata;
    end
  end

  assign source_select = channel_six_output_control[occsc_pkg::SRC_HI:occsc_pkg::SRC_LO];
  assign driver_format = channel_six_output_control[occsc_pkg::FMT_HI:occsc_pkg::FMT_LO];
  assign driver_mode_first = channel_six_output_control[occsc_pkg::MODE1_HI:occsc_pkg::MODE1_LO];
  assign driver_mode_second = channel_six_output_control[occsc_pkg::MODE2_HI:occsc_pkg::MODE2_LO];

  // Sources enter through two flops before anything looks at them
  occsc_sync #(
    .WIDTH(occsc_pkg::SOURCE_COUNT)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({ref_sec_clk, ref_pri_clk, pll2_clk, pll1_clk}),
    .sync_out(src_sync)
  );

  // Source mux; switching is not glitch free
  always_comb begin
    case (source_select)
      occsc_pkg::SRC_PLL1: src_level = src_sync[0];
      occsc_pkg::SRC_PLL2: src_level = src_sync[1];
      occsc_pkg::SRC_REF_PRI: src_level = src_sync[2];
      occsc_pkg::SRC_REF_SEC: src_level = src_sync[3];
      default: src_level = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end
  assign src_rise = src_level && !src_prev;

  occsc_divider u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .src_rise(src_rise),
    .ratio_m1(channel_six_output_divider),
    .div_out(div_level)
  );

  // Ratio one passes the source straight; references always bypass
  always_comb begin
    if (source_select[1] || channel_six_output_divider == 8'h00) begin
      chan_clk = src_prev;
    end else begin
      chan_clk = div_level;
    end
  end

  // Single-ended pin behaviour shared by both pins
  function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic clk);
    case (mode)
      occsc_pkg::PIN_TRISTATE: pin_drive = 2'b00;
      occsc_pkg::PIN_LOW: pin_drive = 2'b10;
      occsc_pkg::PIN_INVERT: pin_drive = {1'b1, ~clk};
      occsc_pkg::PIN_TRUE: pin_drive = {1'b1, clk};
      default: pin_drive = 2'b00;
    endcase
  endfunction

  // Driver decode
  always_comb begin
    next_out_p = 1'b0;
    next_out_p_oe = 1'b0;
    next_out_n = 1'b0;
    next_out_n_oe = 1'b0;
    case (driver_format)
      occsc_pkg::FMT_OFF: begin
        next_out_p_oe = 1'b0;
      end
      occsc_pkg::FMT_AC_DIFF: begin
        next_out_p = chan_clk;
        next_out_p_oe = 1'b1;
        next_out_n = ~chan_clk;
        next_out_n_oe = 1'b1;
      end
      occsc_pkg::FMT_HCSL: begin
        // Tristate load code releases both legs
        next_out_p = chan_clk;
        next_out_n = ~chan_clk;
        next_out_p_oe = (driver_mode_second != occsc_pkg::LOAD_TRISTATE);
        next_out_n_oe = (driver_mode_second != occsc_pkg::LOAD_TRISTATE);
      end
      occsc_pkg::FMT_CMOS: begin
        {next_out_p_oe, next_out_p} = pin_drive(driver_mode_first, chan_clk);
        {next_out_n_oe, next_out_n} = pin_drive(driver_mode_second, chan_clk);
      end
      default: begin
        next_out_p_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_p <= 1'b0;
      out_p_oe <= 1'b0;
      out_n <= 1'b0;
      out_n_oe <= 1'b0;
    end else begin
      out_p <= next_out_p;
      out_p_oe <= next_out_p_oe;
      out_n <= next_out_n;
      out_n_oe <= next_out_n_oe;
    end
  end

  // Analog settings only meaningful in the matching format
  assign tail_current_sel = (driver_format == occsc_pkg::FMT_CMOS) ? 2'h0 : driver_mode_first;
  assign hcsl_load_sel = (driver_format == occsc_pkg::FMT_HCSL) ? driver_mode_second : 2'h0;
endmodule // occsc_top
`default_nettype wire

// *** pkg/occsc_pkg.sv ***
// Constants for the channel six output control block.
// Assumes a 32-bit AHB-Lite register bus and one 125 MHz clock.
package occsc_pkg;
  // Register indices and byte addresses, four bytes per index
  localparam logic [7:0] CTL_INDEX = 8'h29;
  localparam logic [7:0] DIV_INDEX = 8'h2A;
  localparam logic [9:0] CTL_ADDR = {CTL_INDEX, 2'b00};
  localparam logic [9:0] DIV_ADDR = {DIV_INDEX, 2'b00};
  localparam int ADDR_BITS = 10;
  // Control register fields
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 6;
  localparam int FMT_HI = 5;
  localparam int FMT_LO = 4;
  localparam int MODE1_HI = 3;
  localparam int MODE1_LO = 2;
  localparam int MODE2_HI = 1;
  localparam int MODE2_LO = 0;
  // Reset values
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic [1:0] FMT_RESET = 2'h1;
  localparam logic [1:0] MODE1_RESET = 2'h2;
  localparam logic [1:0] MODE2_RESET = 2'h0;
  localparam logic [7:0] CTL_RESET = {SRC_RESET, FMT_RESET, MODE1_RESET, MODE2_RESET};
  localparam logic [7:0] DIV_RESET = 8'h05;
  // Source select codes
  localparam logic [1:0] SRC_PLL1 = 2'h0;
  localparam logic [1:0] SRC_PLL2 = 2'h1;
  localparam logic [1:0] SRC_REF_PRI = 2'h2;
  localparam logic [1:0] SRC_REF_SEC = 2'h3;
  // Driver format codes
  localparam logic [1:0] FMT_OFF = 2'h0;
  localparam logic [1:0] FMT_AC_DIFF = 2'h1;
  localparam logic [1:0] FMT_HCSL = 2'h2;
  localparam logic [1:0] FMT_CMOS = 2'h3;
  // Single-ended pin mode codes
  localparam logic [1:0] PIN_TRISTATE = 2'h0;
  localparam logic [1:0] PIN_LOW = 2'h1;
  localparam logic [1:0] PIN_INVERT = 2'h2;
  localparam logic [1:0] PIN_TRUE = 2'h3;
  // HCSL load codes
  localparam logic [1:0] LOAD_TRISTATE = 2'h0;
  // AHB constants, synchroniser depth and source count
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam int SYNC_STAGES = 2;
  localparam int SOURCE_COUNT = 4;
endpackage

// *** tb/occsc_asserts.sv ***
// Port relation checker for the channel six output control block.
// Assumes binding onto occsc_top; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module occsc_asserts (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus replies
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins and driver settings
  input wire logic out_p,
  input wire logic out_p_oe,
  input wire logic out_n,
  input wire logic out_n_oe,
  input wire logic [1:0] driver_format,
  input wire logic [1:0] tail_current_sel,
  input wire logic [1:0] hcsl_load_sel
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Three cycles, since pin enables lag the register by one
  sequence fmt_held(f);
    (driver_format == f)[*3];
  endsequence
  sequence hcsl_held(tri_load);
    (driver_format == 2'h2 && (hcsl_load_sel == 2'h0) == tri_load)[*3];
  endsequence
  AST_OFF_QUIET: assert property (fmt_held(2'h0) |-> !out_p_oe && !out_n_oe)
    else $error("pins enabled while output off");
  AST_DIFF_PAIR: assert property (fmt_held(2'h1) |-> out_p_oe && out_n_oe && out_p != out_n)
    else $error("differential pair not complementary");
  AST_HCSL_TRI: assert property (hcsl_held(1'b1) |-> !out_p_oe && !out_n_oe)
    else $error("hcsl tristate load still driving");
  AST_HCSL_PAIR: assert property (hcsl_held(1'b0) |-> out_p_oe && out_n_oe && out_p != out_n)
    else $error("hcsl pair not complementary");
  AST_CMOS_TAIL: assert property (driver_format == 2'h3 |-> tail_current_sel == 2'h0)
    else $error("tail current set in single-ended mode");
  AST_LOAD_ZERO: assert property (driver_format != 2'h2 |-> hcsl_load_sel == 2'h0)
    else $error("load select outside hcsl mode");
  AST_DATA_WIDTH: assert property (hreadyout && !hresp |-> hrdata[31:8] == 24'h0)
    else $error("read data wider than eight bits");
  // Second reset edge, since the registers may still be unknown at the first
  AST_RESET_FIELDS: assert property (disable iff (1'b0) (!hresetn) [*2] |-> driver_format == 2'h1 && tail_current_sel == 2'h2 && hcsl_load_sel == 2'h0)
    else $error("driver fields wrong in reset");
endmodule // occsc_asserts
bind occsc_top occsc_asserts u_asserts (.hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .out_p(out_p), .out_p_oe(out_p_oe), .out_n(out_n), .out_n_oe(out_n_oe),
  .driver_format(driver_format), .tail_current_sel(tail_current_sel), .hcsl_load_sel(hcsl_load_sel));
`default_nettype wire

// *** tb/test_output_channel_six_control.sv ***
// Self-checking bench for the channel six output control block.
// Drives the AHB-Lite port and four source clocks directly.
`timescale 1ns/1ns
`default_nettype none
module test_output_channel_six_control;
  localparam logic [9:0] CA = occsc_pkg::CTL_ADDR;
  localparam logic [9:0] DA = occsc_pkg::DIV_ADDR;
  logic hclk, hresetn, hsel, hwrite, hready, pll1_clk, pll2_clk, ref_pri_clk, ref_sec_clk;
  logic hreadyout, hresp, out_p, out_p_oe, out_n, out_n_oe;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, driver_format, tail_current_sel, hcsl_load_sel;
  logic [2:0] hsize;
  logic [3:0] ref_hist;
  int err_total, checked, tick;
  assign hready = hreadyout;
  occsc_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .pll1_clk, .pll2_clk, .ref_pri_clk, .ref_sec_clk, .out_p, .out_p_oe, .out_n,
    .out_n_oe, .driver_format, .tail_current_sel, .hcsl_load_sel);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Source periods of 8, 10, 12 and 14 cycles keep each well below hclk / 4
  always @(posedge hclk) begin
    tick <= tick + 1;
    pll1_clk <= (tick % 8) < 4;
    pll2_clk <= (tick % 10) < 5;
    ref_pri_clk <= (tick % 12) < 6;
    ref_sec_clk <= (tick % 14) < 7;
    // Pins show a reference level four edges after it is set
    ref_hist <= {ref_hist[2:0], ref_pri_clk};
  end
  task complete_run;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task bail;
    err_total++;
    complete_run;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Single word transfer; entered just after a rising edge
  task bus(input logic [9:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
    int n;
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    htrans <= occsc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) bail;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) bail;
    q = hrdata;
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, rd);
  endtask
  task rdc(input logic [9:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00, rd);
    chk(rd, {24'h0, e});
  endtask
  task reset_values;
    rdc(CA, occsc_pkg::CTL_RESET);
    rdc(DA, occsc_pkg::DIV_RESET);
    rdc(10'h0AC, 8'h00);
    @(negedge hclk);
    chk(driver_format, occsc_pkg::FMT_RESET);
    chk(tail_current_sel, occsc_pkg::MODE1_RESET);
    @(posedge hclk);
  endtask
  task fields;
    for (int f = 0; f < 4; f++) begin
      wr(CA, {2'h2, f[1:0], 4'h6});
      rdc(CA, {2'h2, f[1:0], 4'h6});
      @(negedge hclk);
      chk(driver_format, f);
      chk(tail_current_sel, (f == 3) ? 0 : 1);
      chk(hcsl_load_sel, (f == 2) ? 2 : 0);
      @(posedge hclk);
    end
  endtask
  task pins;
    for (int m = 0; m < 4; m++) begin
      wr(CA, {2'h2, 2'h3, m[1:0], m[1:0]});
      repeat (3) @(negedge hclk);
      chk(out_p_oe, m != 0);
      chk(out_n_oe, m != 0);
      if (m == 1) chk({out_p, out_n}, 2'h0);
      if (m > 1) chk(out_p, out_n);
      @(posedge hclk);
    end
    // Inverted first pin against true second pin
    wr(CA, 8'hBB);
    repeat (3) @(negedge hclk);
    repeat (12) begin
      @(negedge hclk);
      chk(out_p ^ out_n, 1);
      chk(out_n, ref_hist[3]);
      chk(out_p, !ref_hist[3]);
    end
    @(posedge hclk);
    // Tristate load releases both legs, a real load drives them
    wr(CA, 8'hA4);
    repeat (3) @(negedge hclk);
    chk({out_p_oe, out_n_oe, hcsl_load_sel}, 4'h0);
    @(posedge hclk);
    wr(CA, 8'hA7);
    repeat (3) @(negedge hclk);
    chk({out_p_oe, out_n_oe, hcsl_load_sel}, 4'hF);
    chk(out_p ^ out_n, 1);
    chk(tail_current_sel, 2'h1);
    @(posedge hclk);
  endtask
  // The periods up to the second rising edge may be partial, so the span from the second to the third rise is timed
  task period(input int exp);
    int n, r, t;
    logic pv;
    n = 0;
    r = 0;
    t = 0;
    pv = out_p;
    while (r < 3 && n < 8000) begin
      @(negedge hclk);
      n++;
      if (out_p === 1'b1 && pv === 1'b0) begin
        r++;
        if (r == 2) t = n;
      end
      pv = out_p;
    end
    if (r < 3) bail;
    chk(32'(n - t), exp);
    @(posedge hclk);
  endtask
  task src_div(input logic [1:0] s, input logic [7:0] d, input int exp);
    wr(DA, d);
    wr(CA, {s, 6'h18});
    period(exp);
  endtask
  initial begin
    err_total = 0;
    checked = 0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_values;
    fields;
    pins;
    src_div(occsc_pkg::SRC_PLL1, 8'h02, 24);
    src_div(occsc_pkg::SRC_PLL2, 8'h02, 30);
    src_div(occsc_pkg::SRC_REF_PRI, 8'h02, 12);
    src_div(occsc_pkg::SRC_REF_SEC, 8'h02, 14);
    src_div(occsc_pkg::SRC_PLL1, 8'h00, 8);
    src_div(occsc_pkg::SRC_PLL1, 8'hFF, 2048);
    complete_run;
  end
endmodule // test_output_channel_six_control
`default_nettype wire
